// *** hdl/ipr_top.sv ***
// I2C slave register port with book/page selection, auto-increment pointer
// and coefficient swap.
// assumes: pins are asynchronous; sample_tick comes from clk_sys logic.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_defines.svh"
module ipr_top #(
    parameter int COEF_PAGES = `IPR_COEF_PAGES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        scl_pin,
    input  wire logic        sda_pin_in,
    output var  logic        sda_pin_out,
    output var  logic        sda_pin_oe_n,
    input  wire logic        adr_pin,
    input  wire logic        sample_tick,
    output var  logic        swap_flag,
    output var  logic [7:0]  book_sel,
    output var  logic [7:0]  page_sel,
    output var  logic [31:0] vol_left,
    output var  logic [31:0] vol_right
);
    localparam int PW = $clog2(COEF_PAGES);
    localparam int AW = PW + 5;
    localparam logic [7:0] PAGES8 = 8'(COEF_PAGES);
    localparam logic [7:0] VOL_PG = `IPR_VOL_PAGE - `IPR_COEF_FIRST_PAGE;

    generate
        if (COEF_PAGES < 2 || (1 << PW) != COEF_PAGES || COEF_PAGES > 64)
        begin : g_bad_pages
            $error("COEF_PAGES must be a power of two from 2 to 64");
        end
        if (VOL_PG >= PAGES8)
        begin : g_no_vol
            $error("COEF_PAGES too small to hold the volume page");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pins and memory

    logic [2:0] pins_s;
    logic       scl;
    logic       sda;
    logic       adr;

    ipr_sync #(
        .WIDTH (3)
    ) u_sync (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .d       ({scl_pin, sda_pin_in, adr_pin}),
        .q       (pins_s)
    );

    assign scl = pins_s[2];
    assign sda = pins_s[1];
    assign adr = pins_s[0];

    ipr_coef_if #(
        .AW (AW)
    ) cif ();

    ipr_coef_mem #(
        .COEF_PAGES (COEF_PAGES)
    ) u_mem (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .sample_tick (sample_tick),
        .cif         (cif.mem),
        .vol_left    (vol_left),
        .vol_right   (vol_right)
    );

    ////////////////////////////////////////////////////////////////////////
    // decode

    ipr_pkg::ipr_top_regs_type r;
    ipr_pkg::ipr_top_regs_type next_r;

    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic [7:0] page_off;
    logic       in_host;
    logic       in_swap;
    logic [6:0] ptr_next;
    logic [7:0] host_byte;
    logic [7:0] rd_byte;

    assign rise  = scl & ~r.scl_p;
    assign fall  = ~scl & r.scl_p;
    assign start = scl & r.scl_p & r.sda_p & ~sda;
    assign stop  = scl & r.scl_p & ~r.sda_p & sda;

    assign page_off = r.page - `IPR_COEF_FIRST_PAGE;
    assign in_host  = (r.book == `IPR_COEF_BOOK)
                    && (r.page >= `IPR_COEF_FIRST_PAGE)
                    && (page_off < PAGES8);
    assign in_swap  = (r.book == `IPR_COEF_BOOK)
                    && (r.page == `IPR_SWAP_PAGE)
                    && (r.ptr >= `IPR_SWAP_REG);

    // wrap keeps the pointer inside the current page
    assign ptr_next = (r.ptr == `IPR_PTR_LAST) ? `IPR_PTR_FIRST
                                               : r.ptr + 7'h01;

    assign cif.ra = {page_off[PW-1:0], r.ptr[6:2]};

    always_comb
    begin
        case (r.ptr[1:0])
            2'h0:    host_byte = cif.rdata[31:24];
            2'h1:    host_byte = cif.rdata[23:16];
            2'h2:    host_byte = cif.rdata[15:8];
            default: host_byte = cif.rdata[7:0];
        endcase
    end

    // byte the pointer selects for the next read
    always_comb
    begin
        if (r.ptr == `IPR_PTR_PAGE)
            rd_byte = r.page;
        else if (r.ptr == `IPR_PTR_BOOK && r.page == `IPR_PAGE_ZERO)
            rd_byte = r.book;
        else if (in_swap)
            rd_byte = (r.ptr == `IPR_PTR_LAST) ? {7'h00, cif.busy} : 8'h00;
        else if (in_host)
            rd_byte = host_byte;
        else
            rd_byte = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // bus state machine

    always_comb
    begin
        logic load;
        load = 1'b0;
        next_r = r;
        next_r.scl_p    = scl;
        next_r.sda_p    = sda;
        next_r.swap_req = 1'b0;
        next_r.host_we  = 1'b0;
        case (r.state)
            ipr_pkg::ST_IDLE:
                next_r.drive = 1'b0;
            ipr_pkg::ST_ADDR:
            begin
                if (rise)
                begin
                    next_r.sh  = {r.sh[6:0], sda};
                    next_r.cnt = r.cnt + 4'h1;
                end
                else if (fall && r.cnt == `IPR_BYTE_BITS)
                begin
                    if (r.sh[7:1] == {`IPR_ADDR_HI, adr})
                    begin
                        next_r.state = ipr_pkg::ST_ACK_A;
                        next_r.drive = 1'b1;
                        next_r.rw    = r.sh[0];
                    end
                    else
                    begin
                        next_r.state = ipr_pkg::ST_IDLE;
                    end
                end
            end
            ipr_pkg::ST_ACK_A:
                if (fall)
                begin
                    next_r.cnt = 4'h0;
                    if (r.rw)
                    begin
                        next_r.state = ipr_pkg::ST_RDATA;
                        load = 1'b1;
                    end
                    else
                    begin
                        next_r.state = ipr_pkg::ST_WDATA;
                        next_r.drive = 1'b0;
                    end
                end
            ipr_pkg::ST_WDATA:
            begin
                if (rise)
                begin
                    next_r.sh  = {r.sh[6:0], sda};
                    next_r.cnt = r.cnt + 4'h1;
                end
                else if (fall && r.cnt == `IPR_BYTE_BITS)
                begin
                    next_r.state = ipr_pkg::ST_ACK_W;
                    next_r.drive = 1'b1;
                    if (r.first)
                    begin
                        // first byte after address+write loads flag and pointer
                        next_r.first  = 1'b0;
                        next_r.inc_en = r.sh[7];
                        next_r.ptr    = r.sh[6:0];
                    end
                    else
                    begin
                        if (r.ptr == `IPR_PTR_PAGE)
                            next_r.page = r.sh;
                        else if (r.ptr == `IPR_PTR_BOOK && r.page == `IPR_PAGE_ZERO)
                            next_r.book = r.sh;
                        else if (in_swap)
                        begin
                            next_r.trig = {r.trig[15:0], r.sh};
                            if (r.ptr == `IPR_PTR_LAST && {r.trig, r.sh} == `IPR_SWAP_VALUE)
                                next_r.swap_req = 1'b1;
                        end
                        else if (in_host)
                        begin
                            next_r.host_we   = 1'b1;
                            next_r.host_pg   = page_off;
                            next_r.host_ptr  = r.ptr;
                            next_r.host_byte = r.sh;
                        end
                        if (r.inc_en)
                            next_r.ptr = ptr_next;
                    end
                end
            end
            ipr_pkg::ST_ACK_W:
                if (fall)
                begin
                    next_r.state = ipr_pkg::ST_WDATA;
                    next_r.drive = 1'b0;
                    next_r.cnt   = 4'h0;
                end
            ipr_pkg::ST_RDATA:
                if (fall)
                begin
                    if (r.cnt == `IPR_LAST_BIT)
                    begin
                        next_r.state = ipr_pkg::ST_ACK_R;
                        next_r.drive = 1'b0;
                    end
                    else
                    begin
                        next_r.sh    = {r.sh[6:0], 1'b0};
                        next_r.drive = ~r.sh[6];
                        next_r.cnt   = r.cnt + 4'h1;
                    end
                end
            ipr_pkg::ST_ACK_R:
            begin
                if (rise)
                    next_r.acked = ~sda;
                else if (fall)
                begin
                    next_r.cnt = 4'h0;
                    if (r.acked)
                    begin
                        next_r.state = ipr_pkg::ST_RDATA;
                        load = 1'b1;
                    end
                    else
                    begin
                        next_r.state = ipr_pkg::ST_IDLE; // nack ends the read
                    end
                end
            end
            default:
            begin
                next_r.state = ipr_pkg::ST_IDLE;
                next_r.drive = 1'b0;
            end
        endcase
        if (load)
        begin
            next_r.sh    = rd_byte;
            next_r.drive = ~rd_byte[7];
            if (r.inc_en)
                next_r.ptr = ptr_next;
        end
        if (start) // start and repeated start
        begin
            next_r.state = ipr_pkg::ST_ADDR;
            next_r.cnt   = 4'h0;
            next_r.drive = 1'b0;
            next_r.first = 1'b1;
        end
        else if (stop)
        begin
            next_r.state = ipr_pkg::ST_IDLE;
            next_r.drive = 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r <= '{state: ipr_pkg::ST_IDLE,
                   scl_p: 1'b1,
                   sda_p: 1'b1,
                   book:  `IPR_BOOK_RST,
                   page:  `IPR_PAGE_RST,
                   default: '0};
        end
        else
        begin
            r <= next_r; // selectors only change on their own writes
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign cif.we       = r.host_we;
    assign cif.wa       = {r.host_pg[PW-1:0], r.host_ptr[6:2]};
    assign cif.lane     = r.host_ptr[1:0];
    assign cif.wbyte    = r.host_byte;
    assign cif.swap_req = r.swap_req;

    assign sda_pin_out  = 1'b0;
    assign sda_pin_oe_n = ~r.drive;
    assign swap_flag    = cif.busy;
    assign book_sel     = r.book;
    assign page_sel     = r.page;
endmodule // ipr_top
`default_nettype wire

// *** hdl/ipr_defines.svh ***
// constants for the paged register port: bus address, selector offsets,
// coefficient book layout, swap word and reset values.
// assumes: included by bare name from every design file that needs it.
`ifndef IPR_DEFINES_SVH
`define IPR_DEFINES_SVH

`define IPR_ADDR_HI         6'h25
`define IPR_BYTE_BITS       4'h8
`define IPR_LAST_BIT        4'h7
`define IPR_PTR_PAGE        7'h00
`define IPR_PTR_BOOK        7'h7F
`define IPR_PTR_FIRST       7'h00
`define IPR_PTR_LAST        7'h7F
`define IPR_PAGE_ZERO       8'h00
`define IPR_BOOK_RST        8'h00
`define IPR_PAGE_RST        8'h00
`define IPR_COEF_BOOK       8'h8C
`define IPR_COEF_FIRST_PAGE 8'h1C
`define IPR_COEF_PAGES      8
`define IPR_SWAP_PAGE       8'h05
`define IPR_SWAP_REG        7'h7C
`define IPR_SWAP_VALUE      32'h00000001
`define IPR_VOL_PAGE        8'h21
`define IPR_VOL_LEFT        7'h34
`define IPR_VOL_RIGHT       7'h38
`define IPR_CLK_HZ          40000000
`define IPR_FS_HZ           48000
`define IPR_SAMPLE_CYCLES   (`IPR_CLK_HZ / `IPR_FS_HZ)

`endif

// *** hdl/ipr_pkg.sv ***
// types of the paged register port: bus state machine, copy engine states
// and the register state of the top module.
// assumes: compiled before every design file.
package ipr_pkg;

    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_ADDR  = 7'h02,
        ST_ACK_A = 7'h04,
        ST_WDATA = 7'h08,
        ST_ACK_W = 7'h10,
        ST_RDATA = 7'h20,
        ST_ACK_R = 7'h40
    } ipr_state_type;

    typedef enum logic [2:0] {
        CP_IDLE = 3'h1,
        CP_WAIT = 3'h2,
        CP_COPY = 3'h4
    } ipr_copy_type;

    typedef struct packed {
        ipr_state_type state;
        logic          scl_p;
        logic          sda_p;
        logic [3:0]    cnt;
        logic [7:0]    sh;
        logic          rw;
        logic          first;
        logic          acked;
        logic          drive;
        logic [6:0]    ptr;
        logic          inc_en;
        logic [7:0]    book;
        logic [7:0]    page;
        logic [23:0]   trig;
        logic          swap_req;
        logic          host_we;
        logic [7:0]    host_pg;
        logic [6:0]    host_ptr;
        logic [7:0]    host_byte;
    } ipr_top_regs_type;

endpackage

// *** hdl/ipr_coef_if.sv ***
// carries host-buffer writes and reads and the swap handshake between the
// register port and the coefficient memory.
// assumes: one clock domain, both ends on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface ipr_coef_if #(parameter int AW = 8);
    logic          we;
    logic [AW-1:0] wa;
    logic [1:0]    lane;
    logic [7:0]    wbyte;
    logic [AW-1:0] ra;
    logic [31:0]   rdata;
    logic          swap_req;
    logic          busy;
    modport port (output we, wa, lane, wbyte, ra, swap_req, input rdata, busy);
    modport mem  (input we, wa, lane, wbyte, ra, swap_req, output rdata, busy);
endinterface
`default_nettype wire

// *** hdl/ipr_sync.sv ***
// two-flop synchroniser for pin inputs.
// assumes: inputs asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module ipr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_sys,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] d,
    output var  logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            meta <= '1;
            q    <= '1;
        end
        else
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // ipr_sync
`default_nettype wire

// *** hdl/ipr_coef_mem.sv ***
// host and DSP coefficient memories with the swap copy engine.
// assumes: sample_tick is a one-cycle pulse at the audio sample rate.
`timescale 1ns/1ps
`default_nettype none
`include "ipr_defines.svh"
module ipr_coef_mem #(
    parameter int COEF_PAGES    = `IPR_COEF_PAGES,
    parameter int SAMPLE_CYCLES = `IPR_SAMPLE_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic        sample_tick,
    ipr_coef_if.mem          cif,
    output var  logic [31:0] vol_left,
    output var  logic [31:0] vol_right
);
    localparam int PW    = $clog2(COEF_PAGES);
    localparam int AW    = PW + 5;
    localparam int WORDS = COEF_PAGES * 32;
    localparam logic [7:0] VOL_PG = `IPR_VOL_PAGE - `IPR_COEF_FIRST_PAGE;
    localparam logic [6:0] VOL_L  = `IPR_VOL_LEFT;
    localparam logic [6:0] VOL_R  = `IPR_VOL_RIGHT;
    localparam logic [AW-1:0] L_IDX = {VOL_PG[PW-1:0], VOL_L[6:2]};
    localparam logic [AW-1:0] R_IDX = {VOL_PG[PW-1:0], VOL_R[6:2]};
    localparam logic [AW-1:0] LAST  = AW'(WORDS - 1);

    generate
        if (WORDS > SAMPLE_CYCLES)
        begin : g_too_slow
            $error("host buffer cannot be copied within one sample");
        end
    endgenerate

    typedef struct packed {
        ipr_pkg::ipr_copy_type cp;
        logic                  pend;
        logic                  busy;
        logic [AW-1:0]         idx;
        logic [31:0]           vl;
        logic [31:0]           vr;
    } ipr_mem_regs_type;

    ipr_mem_regs_type r, next_r;
    logic [31:0] host_mem [WORDS];
    logic [31:0] dsp_mem  [WORDS];

    assign cif.rdata = host_mem[cif.ra];
    assign cif.busy  = r.busy;
    assign vol_left  = r.vl;
    assign vol_right = r.vr;

    always_comb
    begin
        next_r = r;
        next_r.vl = dsp_mem[L_IDX];
        next_r.vr = dsp_mem[R_IDX];
        if (cif.swap_req)
            next_r.pend = 1'b1;
        case (r.cp)
            ipr_pkg::CP_IDLE:
                if (r.pend)
                begin
                    next_r.cp   = sample_tick ? ipr_pkg::CP_COPY : ipr_pkg::CP_WAIT;
                    next_r.pend = cif.swap_req;
                end
            ipr_pkg::CP_WAIT:
                if (sample_tick) // copy runs right after a sample edge
                begin
                    next_r.cp  = ipr_pkg::CP_COPY;
                    next_r.idx = '0;
                end
            ipr_pkg::CP_COPY:
            begin
                next_r.idx = r.idx + AW'(1);
                if (r.idx == LAST)
                    next_r.cp = ipr_pkg::CP_IDLE;
            end
            default:
                next_r.cp = ipr_pkg::CP_IDLE;
        endcase
        next_r.busy = (next_r.cp != ipr_pkg::CP_IDLE) || next_r.pend;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            r <= '{cp: ipr_pkg::CP_IDLE, default: '0};
        end
        else
        begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (cif.we) // host side only, DSP side untouched
            host_mem[cif.wa][8*(3-cif.lane) +: 8] <= cif.wbyte;
        if (r.cp == ipr_pkg::CP_COPY)
            dsp_mem[r.idx] <= host_mem[r.idx];
    end
endmodule // ipr_coef_mem
`default_nettype wire

// *** tb/ipr_i2c_host.sv ***
// I2C bus master model: drives SCL, pulls SDA low, byte tasks.
// assumes: the bench resolves the SDA wire with a pull-up.
`timescale 1ns/1ps
`default_nettype none
module ipr_i2c_host #(
    parameter int HALF = 8
) (
    input  wire logic clk_sys,
    input  wire logic sda_in,
    output var  logic scl,
    output var  logic sda_oe_n
);
    initial
    begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // sda held two cycles after scl falls so the synchronised pins never race
    task automatic start_cond();
        wait_clk(2);
        sda_oe_n = 1'b1;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        sda_oe_n = 1'b0;
        wait_clk(HALF);
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        wait_clk(2);
        sda_oe_n = 1'b0;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        sda_oe_n = 1'b1;
        wait_clk(HALF);
    endtask
    task automatic bit_xfer(input logic b_out, output logic b_in);
        wait_clk(2);
        sda_oe_n = b_out;
        wait_clk(HALF - 2);
        scl = 1'b1;
        wait_clk(HALF / 2);
        b_in = sda_in;
        wait_clk(HALF / 2);
        scl = 1'b0;
    endtask
    task automatic send(input logic [7:0] b, output logic ack);
        logic unused;
        for (int i = 7; i >= 0; i--)
            bit_xfer(b[i], unused);
        bit_xfer(1'b1, ack);
    endtask
    // nack high on the last byte of a read
    task automatic recv(input logic nack, output logic [7:0] b);
        logic unused;
        for (int i = 7; i >= 0; i--)
            bit_xfer(1'b1, b[i]);
        bit_xfer(nack, unused);
    endtask
endmodule // ipr_i2c_host
`default_nettype wire

// *** tb/ipr_top_properties.sv ***
// checker of the paged register port on the top module's ports.
// assumes: bound onto every ipr_top instance.
`timescale 1ns/1ps
`default_nettype none
module ipr_top_properties #(
    parameter int COEF_PAGES = 8
) (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        scl_pin,
    input wire logic        sda_pin_in,
    input wire logic        sda_pin_out,
    input wire logic        sda_pin_oe_n,
    input wire logic        adr_pin,
    input wire logic        sample_tick,
    input wire logic        swap_flag,
    input wire logic [7:0]  book_sel,
    input wire logic [7:0]  page_sel,
    input wire logic [31:0] vol_left,
    input wire logic [31:0] vol_right
);
    localparam int COPY_MAX = COEF_PAGES * 32 + 4;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////
    drive_low_a: assert property (!sda_pin_out)
        else $error("sda output not low");
    reset_state_a: assert property ($fell(sys_rst) |-> sda_pin_oe_n && !swap_flag && book_sel == 8'h00
        && page_sel == 8'h00) else $error("reset state wrong");
    book_gate_a: assert property ($changed(book_sel) && !$past(sys_rst) |-> $past(page_sel) == 8'h00)
        else $error("book changed off page zero");
    sel_hold_a: assert property (($changed(book_sel) || $changed(page_sel)) && !$past(sys_rst)
        |-> !scl_pin && !$past(scl_pin, 2)) else $error("selector changed outside a byte end");
    oe_scl_low_a: assert property ($changed(sda_pin_oe_n) && !$past(sys_rst)
        |-> !scl_pin && !$past(scl_pin, 2)) else $error("sda drive changed with scl high");
    swap_hold_a: assert property ($rose(swap_flag) |-> swap_flag [*8])
        else $error("swap flag dropped early");
    swap_done_a: assert property (sample_tick && swap_flag |-> ##[1:COPY_MAX] !swap_flag)
        else $error("swap copy too long");
    swap_place_a: assert property ($rose(swap_flag) |-> book_sel == 8'h8C && page_sel == 8'h05)
        else $error("swap from wrong page");
    vol_swap_a: assert property ($changed(vol_left) || $changed(vol_right)
        |-> $past(swap_flag) || $past(swap_flag, 2) || $past(swap_flag, 4)) else $error("volume moved without swap");
    cover property ($rose(swap_flag));
    cover property ($changed(book_sel));
    cover property ($fell(sda_pin_oe_n));
endmodule // ipr_top_properties
bind ipr_top ipr_top_properties #(.COEF_PAGES(COEF_PAGES)) ipr_top_properties_inst (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in),
    .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n), .adr_pin(adr_pin), .sample_tick(sample_tick),
    .swap_flag(swap_flag), .book_sel(book_sel), .page_sel(page_sel), .vol_left(vol_left), .vol_right(vol_right));
`default_nettype wire

// *** tb/i2c_paged_register_port_tb.sv ***
// self-checking bench of the paged register port with an I2C master model.
// assumes: ipr_top, ipr_i2c_host and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module i2c_paged_register_port_tb;
    localparam int COEF_PAGES = 8;
    localparam int TICK = 1200;
    logic        clk_sys;
    logic        sys_rst = 1'b1;
    logic        adr_pin = 1'b0;
    logic        sample_tick = 1'b0;
    logic        scl_w;
    logic        host_oe_n;
    logic        sda_w;
    logic        sda_pin_out;
    logic        sda_pin_oe_n;
    logic        swap_flag;
    logic [7:0]  book_sel;
    logic [7:0]  page_sel;
    logic [31:0] vol_left;
    logic [31:0] vol_right;
    int          tick_cnt = 0;
    int          cycles = 0;
    int          bad_count = 0;
    int          samples_checked = 0;
    // pull-up: the wire is low while either party drives
    assign sda_w = host_oe_n & (sda_pin_oe_n | sda_pin_out);
    ipr_top #(.COEF_PAGES(COEF_PAGES)) ipr_top_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_pin(scl_w),
        .sda_pin_in(sda_w), .sda_pin_out(sda_pin_out), .sda_pin_oe_n(sda_pin_oe_n), .adr_pin(adr_pin),
        .sample_tick(sample_tick), .swap_flag(swap_flag), .book_sel(book_sel), .page_sel(page_sel),
        .vol_left(vol_left), .vol_right(vol_right));
    ipr_i2c_host #(.HALF(8)) ipr_i2c_host_inst (.clk_sys(clk_sys), .sda_in(sda_w), .scl(scl_w),
        .sda_oe_n(host_oe_n));
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    always @(negedge clk_sys)
    begin
        tick_cnt <= (tick_cnt == TICK - 1) ? 0 : tick_cnt + 1;
        sample_tick <= (tick_cnt == TICK - 1);
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            bad_count++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic open_wr(input logic [6:0] reg_a, input logic inc);
        logic ack;
        ipr_i2c_host_inst.start_cond();
        ipr_i2c_host_inst.send({6'h25, adr_pin, 1'b0}, ack);
        check("addr ack", {31'h0, ack}, 32'h0);
        ipr_i2c_host_inst.send({inc, reg_a}, ack);
        check("reg ack", {31'h0, ack}, 32'h0);
    endtask
    task automatic wr1(input logic [6:0] reg_a, input logic [7:0] b);
        logic ack;
        open_wr(reg_a, 1'b1);
        ipr_i2c_host_inst.send(b, ack);
        check("data ack", {31'h0, ack}, 32'h0);
        ipr_i2c_host_inst.stop_cond();
    endtask
    task automatic wr4(input logic [6:0] reg_a, input logic [31:0] w);
        logic ack;
        open_wr(reg_a, 1'b1);
        for (int i = 3; i >= 0; i--)
        begin
            ipr_i2c_host_inst.send(w[i*8 +: 8], ack);
            check("word ack", {31'h0, ack}, 32'h0);
        end
        ipr_i2c_host_inst.stop_cond();
    endtask
    task automatic rd(input logic [6:0] reg_a, input int n, output logic [7:0] q [4]);
        logic ack;
        open_wr(reg_a, 1'b1);
        ipr_i2c_host_inst.start_cond();
        ipr_i2c_host_inst.send({6'h25, adr_pin, 1'b1}, ack);
        check("read ack", {31'h0, ack}, 32'h0);
        for (int i = 0; i < n; i++)
            ipr_i2c_host_inst.recv(i == n - 1, q[i]);
        ipr_i2c_host_inst.stop_cond();
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_addr();
        logic ack;
        check("reset page", {24'h0, page_sel}, 32'h0);
        ipr_i2c_host_inst.start_cond();
        ipr_i2c_host_inst.send(8'h96, ack);
        check("foreign nack", {31'h0, ack}, 32'h1);
        ipr_i2c_host_inst.send(8'h80, ack);
        ipr_i2c_host_inst.send(8'h09, ack);
        ipr_i2c_host_inst.stop_cond();
        check("page untouched", {24'h0, page_sel}, 32'h0);
        adr_pin = 1'b1;
        wr1(7'h00, 8'h07);
        check("page at 0x96", {24'h0, page_sel}, 32'h07);
        adr_pin = 1'b0;
    endtask
    task automatic t_book();
        logic ack;
        wr1(7'h7F, 8'h8C);
        check("book refused", {24'h0, book_sel}, 32'h0);
        wr1(7'h00, 8'h00);
        wr1(7'h7F, 8'h8C);
        check("book set", {24'h0, book_sel}, 32'h8C);
        open_wr(7'h00, 1'b0);
        ipr_i2c_host_inst.send(8'h22, ack);
        ipr_i2c_host_inst.send(8'h21, ack);
        ipr_i2c_host_inst.stop_cond();
        check("page set", {24'h0, page_sel}, 32'h21);
        check("book kept", {24'h0, book_sel}, 32'h8C);
    endtask
    task automatic t_wrap();
        logic [7:0] q [4];
        wr4(7'h7C, 32'hA1B2C3D4);
        rd(7'h7E, 3, q);
        check("byte 7E", {24'h0, q[0]}, 32'hC3);
        check("byte 7F", {24'h0, q[1]}, 32'hD4);
        check("byte 00", {24'h0, q[2]}, 32'h21);
    endtask
    task automatic t_swap();
        logic [7:0] q [4];
        int         n;
        wr4(7'h34, 32'h40000000);
        wr4(7'h38, 32'h12345678);
        check("vol held", {31'h0, vol_left === 32'h40000000}, 32'h0);
        wr1(7'h00, 8'h05);
        wr4(7'h7C, 32'h00000001);
        check("swap on", {31'h0, swap_flag}, 32'h1);
        n = 0;
        // host buffer left alone until the flag clears
        while (swap_flag === 1'b1 && n < TICK + 400)
        begin
            @(negedge clk_sys);
            n++;
        end
        check("swap off", {31'h0, swap_flag}, 32'h0);
        check("copy long", {31'h0, n >= COEF_PAGES * 32 - 64}, 32'h1);
        repeat (4) @(negedge clk_sys);
        check("vol left", vol_left, 32'h40000000);
        check("vol right", vol_right, 32'h12345678);
        rd(7'h7F, 1, q);
        check("flag reg", {24'h0, q[0]}, 32'h0);
    endtask
    initial
    begin
        repeat (5) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_addr();
        t_book();
        t_wrap();
        t_swap();
        finish_test();
    end
endmodule // i2c_paged_register_port_tb
`default_nettype wire
